// *** hdl/kms_key_scan.sv ***
`timescale 1ns/10ps
`include "kms_defines.svh"
module kms_key_scan import kms_pkg::*; #(
  parameter int SLOT_TICKS = `KMS_SLOT_TICKS // oscillator ticks per slot
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] port_pins_low_four,
  output logic port_pin_four_interrupt_out,
  output logic port_pin_four_interrupt_oe,
  output logic [7:0] cathode_drive_outputs,
  output logic segment_drive_all,
  output logic decimal_point_segment,
  output logic display_test_active
);
  localparam kms_core_st_t CORE_RST = '{ctrl: `KMS_CTRL_RST,
    osc_div: 6'(`KMS_DIV_NOM), default: '0};

  // register map, byte addresses, 32-bit words
  // 0x00 control: [3:0] lines given to key scanning,
  //   [4] pin four level while scanning is off,
  //   [5] display test, [8:6] highest cathode driven
  // 0x04 oscillator divide, clocks per oscillator tick;
  //   writes are clamped into the 1 to 8 MHz range
  // 0x08 status: [0] interrupt, [3:1] cathode, [7:4] phase
  // 0x10..0x1c interrupt masks, lines A to D, write-only
  // 0x20..0x2c pressed status, lines A to D
  // 0x30..0x3c debounced status, lines A to D, read clears
  // other addresses read zero and ignore writes
  // key words use bits [7:0]; bit i is cathode i

  // bus timing seen from the master
  // edge 1: request seen, ack set, read word captured
  // edge 2: waitrequest low, write lands, read taken
  // the master holds address, data and direction to edge 2
  // a following request gets its own wait state
  // an unmapped read still completes, returning zero

  // scan timeline, counted in cathode slots
  // one slot is SLOT_TICKS oscillator ticks, one cathode low
  // one cycle is 128 slots, 25.6 ms at a 4 MHz oscillator
  // slots 0 to 7: first test, each driven cathode seen at least once
  // slots 8 to 71: debounce gap, nothing sampled
  // slots 72 to 79: second test, each driven cathode seen again
  // slots 80 to 127: rest until the next first test
  // a key is credited only on the last clock of its slot,
  // so a return settling late in the slot still counts
  // the divide stretches every interval alike; halving the
  // oscillator doubles the debounce gap too

  // what a closure looks like
  // each key joins a return line to a cathode via a diode
  // with its cathode low a closed key pulls the line down;
  // otherwise the pull-up holds the line high
  // a low return in cathode i's slot means key i is closed;
  // return j maps to word j of each status group

  // debounce bookkeeping
  // hit1 gathers closures seen in the first test
  // hit2 gathers closures seen in the second test
  // a key closed in both tests is a candidate to report
  // held marks keys reported and still down; a test that
  // sees the key open clears it, the only way a key can
  // be reported a second time
  // pressed shows whichever test ended last
  // debounced bits are sticky until a read clears them
  // no order or repeat count is kept: two presses between
  // reads look exactly like one
  // the host should read all four debounced words after
  // each interrupt, before the next cycle, to lose nothing

  // scan limit
  // with limit n, cathodes 0 to n are driven in turn, so
  // only 4 * (n + 1) keys are read; keys on higher cathodes
  // keep their status bits at zero
  // all 32 keys are read only when all eight are driven
  // a line not given to scanning never reports a closure

  // interrupt and pin four
  // the interrupt is a level in a flop, never a pulse
  // set by an enabled key turning debounced, cleared by
  // any completed read of a debounced word
  // an event in the clearing cycle wins, so a key that
  // debounces while the host reads is not lost
  // with any line scanning, pin four is an open-drain
  // request, driven low while the interrupt is up and
  // left to its pull-up otherwise; with scanning off it
  // is a plain output carrying control bit four

  // display test
  // all segments and points lit for 7/16 of every slot
  // every cathode is driven whatever the scan limit, and
  // keys keep being scanned over all eight meanwhile
  // the control word is untouched, so clearing the test
  // bit restores the previous display at once

  // reset values
  // control: no line scanning, limit at eight cathodes
  // divide: 4 MHz oscillator from the 40 MHz clock
  // masks, status and interrupt cleared
  // cathode 0 low, segments dark, waitrequest up
  // reset is synchronous and wins over a low ce

  // limitations and trade-offs
  // the return pins are asynchronous; two flops sit in
  // front of any logic, costing two clocks of a slot
  // thousands of clocks long, so no closure is misread
  // ce low freezes scanning, status and bus alike; an
  // access simply waits until ce comes back
  // a debounced read clears only the bits it returned,
  // keeping a key that debounces during the access
  // the slot length may be lowered for quick runs; it
  // must not exceed 1024, the tick counter is ten bits

  // state layout
  // all core flops live in one packed struct, filled by
  // one combinational process and registered by one
  // clocked process; timer and bus slave keep their own

  kms_reg_if rif (); // register strobes from the bus slave
  kms_tmr_if tmr (); // slot timing from the sequencer

  kms_core_st_t r; // all core state
  kms_core_st_t next_r;

  logic [3:0] key_en; // return lines given to key scanning
  logic scan_on; // any line scanning
  logic [3:0] closed; // synchronised returns read as closed
  kms_keys_t samp; // closures seen at this slot end
  kms_keys_t hit1_n; // first window closures incl. this slot
  kms_keys_t hit2_n; // second window closures incl. this slot
  kms_keys_t newly; // keys debounced at this edge
  logic deb_rd; // a debounced register is being read
  logic irq_set; // an enabled key debounced now
  logic [1:0] line; // return line addressed by the bus
  logic [5:0] div_w; // oscillator divide requested by a write

  // bus slave: one wait state per access
  kms_avmm_slave u_slave (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .address(avs_address),
    .read(avs_read),
    .write(avs_write),
    .writedata(avs_writedata),
    .readdata(avs_readdata),
    .waitrequest(avs_waitrequest),
    .rif(rif)
  );

  // slot and window sequencer
  kms_scan_timer #(.SLOT_TICKS(SLOT_TICKS)) u_timer (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .tmr(tmr)
  );

  assign key_en = r.ctrl[`KMS_CTRL_KEY_EN +: 4];
  assign scan_on = |key_en;
  assign line = kms_reg_line(rif.addr);
  assign tmr.osc_div = r.osc_div;
  // display test forces all eight digits; the stored limit stays intact
  assign tmr.limit = r.ctrl[`KMS_CTRL_TEST] ? `KMS_LIMIT_ALL :
    r.ctrl[`KMS_CTRL_LIMIT +: 3];

  // key sampling, debounce, sticky status and interrupt
  always_comb begin
    next_r = r;
    // two-stage synchroniser on the return pins
    next_r.sync[0] = port_pins_low_four;
    next_r.sync[1] = r.sync[0];
    // pulled-up return low means closed; disabled lines never count
    closed = ~r.sync[1] & key_en;
    // only the cathode now low is credited, so cathodes past the
    // scan limit are simply never read
    for (int l = 0; l < 4; l++) begin
      samp[l] = closed[l] ? (8'h01 << tmr.cath) : 8'h00;
    end
    hit1_n = r.hit1;
    hit2_n = r.hit2;
    if (tmr.slot_end && tmr.phase == KMS_PH_FIRST) begin
      hit1_n = r.hit1 | samp;
    end
    if (tmr.slot_end && tmr.phase == KMS_PH_SECOND) begin
      hit2_n = r.hit2 | samp;
    end
    next_r.hit1 = hit1_n;
    next_r.hit2 = hit2_n;
    newly = '0;
    // end of first test: publish result, note releases
    if (tmr.first_end) begin
      next_r.pressed = hit1_n;
      next_r.held = r.held & hit1_n;
    end
    // end of second test: confirm closures not already reported
    if (tmr.second_end) begin
      newly = r.hit1 & hit2_n & ~r.held;
      next_r.pressed = hit2_n;
      next_r.held = (r.held & hit2_n) | newly;
      next_r.hit1 = '0;
      next_r.hit2 = '0;
    end
    // register writes
    div_w = rif.wdata[5:0];
    if (rif.wr_stb) begin
      if (rif.addr == `KMS_REG_CTRL) begin
        next_r.ctrl = rif.wdata[8:0];
      end else if (rif.addr == `KMS_REG_DIV) begin
        // clamp to the 1..8 MHz oscillator range
        if (div_w < 6'(`KMS_DIV_MIN)) begin
          next_r.osc_div = 6'(`KMS_DIV_MIN);
        end else if (div_w > 6'(`KMS_DIV_MAX)) begin
          next_r.osc_div = 6'(`KMS_DIV_MAX);
        end else begin
          next_r.osc_div = div_w;
        end
      end else if (kms_reg_hit(rif.addr, `KMS_REG_MASK)) begin
        next_r.mask[line] = rif.wdata[7:0];
      end
    end
    // a debounced read clears only the bits it returned, then new
    // events are or-ed in, so a set in the clearing cycle survives
    deb_rd = rif.rd_stb & kms_reg_hit(rif.addr, `KMS_REG_DEB);
    if (deb_rd) begin
      next_r.debounced[line] = r.debounced[line] & ~rif.rd_q[7:0];
    end
    next_r.debounced = next_r.debounced | newly;
    // interrupt is a level: set by enabled events, cleared by reads
    irq_set = |(newly & r.mask);
    next_r.irq = (r.irq & ~deb_rd) | irq_set;
  end

  // read mux; pressed reads have no side effect anywhere
  always_comb begin
    rif.rdata = '0;
    if (rif.addr == `KMS_REG_CTRL) begin
      rif.rdata[8:0] = r.ctrl;
    end else if (rif.addr == `KMS_REG_DIV) begin
      rif.rdata[5:0] = r.osc_div;
    end else if (rif.addr == `KMS_REG_STAT) begin
      rif.rdata[`KMS_STAT_IRQ] = r.irq;
      rif.rdata[`KMS_STAT_CATH +: 3] = tmr.cath;
      rif.rdata[`KMS_STAT_PHASE +: 4] = tmr.phase;
    end else if (kms_reg_hit(rif.addr, `KMS_REG_PRESS)) begin
      rif.rdata[7:0] = r.pressed[kms_reg_line(rif.addr)];
    end else if (kms_reg_hit(rif.addr, `KMS_REG_DEB)) begin
      rif.rdata[7:0] = r.debounced[kms_reg_line(rif.addr)];
    end
    // masks are write-only and read as zero
  end

  // cathodes double as the scan drive
  assign cathode_drive_outputs = tmr.cath_n;
  // with scanning on, pin four is an active-low open-drain request
  // line; otherwise it is a plain push-pull output
  assign port_pin_four_interrupt_out = scan_on ? 1'b0 :
    r.ctrl[`KMS_CTRL_GPIO4];
  assign port_pin_four_interrupt_oe = scan_on ? r.irq : 1'b1;
  // all segments and points on at fixed duty in display test
  assign display_test_active = r.ctrl[`KMS_CTRL_TEST];
  assign segment_drive_all = r.ctrl[`KMS_CTRL_TEST] & tmr.seg_on;
  assign decimal_point_segment = r.ctrl[`KMS_CTRL_TEST] &
    tmr.seg_on;

  // state register; srst wins over a low enable
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= CORE_RST;
    end else if (ce) begin
      r <= next_r;
    end
  end
endmodule // kms_key_scan

// *** hdl/kms_defines.svh ***
`ifndef KMS_DEFINES_SVH
`define KMS_DEFINES_SVH
// system clock and oscillator rates in MHz
`define KMS_CLK_MHZ 40
`define KMS_OSC_NOM_MHZ 4
`define KMS_OSC_MIN_MHZ 1
`define KMS_OSC_MAX_MHZ 8
// system clocks per oscillator tick
`define KMS_DIV_NOM (`KMS_CLK_MHZ / `KMS_OSC_NOM_MHZ)
`define KMS_DIV_MIN (`KMS_CLK_MHZ / `KMS_OSC_MAX_MHZ)
`define KMS_DIV_MAX (`KMS_CLK_MHZ / `KMS_OSC_MIN_MHZ)
// scan times in microseconds at the nominal oscillator
`define KMS_SLOT_US 200
`define KMS_TEST_US 1600
`define KMS_DEB_US 12800
`define KMS_CYCLE_US 25600
`define KMS_SLOT_TICKS (`KMS_SLOT_US * `KMS_OSC_NOM_MHZ)
`define KMS_TEST_SLOTS (`KMS_TEST_US / `KMS_SLOT_US)
`define KMS_DEB_SLOTS (`KMS_DEB_US / `KMS_SLOT_US)
`define KMS_CYCLE_SLOTS (`KMS_CYCLE_US / `KMS_SLOT_US)
// display test duty, in sixteenths of a slot
`define KMS_DUTY_NUM 7
`define KMS_DUTY_DEN 16
`define KMS_DUTY_TICKS (`KMS_SLOT_TICKS * `KMS_DUTY_NUM / `KMS_DUTY_DEN)
// register byte offsets
`define KMS_REG_CTRL 8'h00
`define KMS_REG_DIV 8'h04
`define KMS_REG_STAT 8'h08
`define KMS_REG_MASK 8'h10
`define KMS_REG_PRESS 8'h20
`define KMS_REG_DEB 8'h30
// control fields and reset values
`define KMS_CTRL_KEY_EN 0
`define KMS_CTRL_GPIO4 4
`define KMS_CTRL_TEST 5
`define KMS_CTRL_LIMIT 6
`define KMS_CTRL_RST 9'h1c0
`define KMS_LIMIT_ALL 3'h7
`define KMS_CATH_N_RST 8'hfe
// status fields
`define KMS_STAT_IRQ 0
`define KMS_STAT_CATH 1
`define KMS_STAT_PHASE 4
`endif

// *** hdl/kms_pkg.sv ***
package kms_pkg;
  `include "kms_defines.svh"
  // four return lines by eight cathodes; bit i is cathode i
  typedef logic [3:0][7:0] kms_keys_t;
  typedef enum logic [3:0] {
    KMS_PH_FIRST = 4'b0001,
    KMS_PH_WAIT = 4'b0010,
    KMS_PH_SECOND = 4'b0100,
    KMS_PH_REST = 4'b1000
  } kms_phase_t;
  typedef struct packed {
    kms_phase_t phase;
    logic [5:0] osc_cnt;
    logic [9:0] tick_cnt;
    logic [6:0] slot_ix;
    logic [2:0] cath;
    logic [7:0] cath_n;
    logic seg_on;
  } kms_tmr_st_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } kms_slv_st_t;
  typedef struct packed {
    logic [1:0][3:0] sync;
    logic [8:0] ctrl;
    logic [5:0] osc_div;
    kms_keys_t mask;
    kms_keys_t pressed;
    kms_keys_t debounced;
    kms_keys_t held;
    kms_keys_t hit1;
    kms_keys_t hit2;
    logic irq;
  } kms_core_st_t;
  // address falls in the 16-byte group at base
  function automatic logic kms_reg_hit(logic [7:0] a, logic [7:0] base);
    return a[7:4] == base[7:4];
  endfunction
  // return line selected by a group address
  function automatic logic [1:0] kms_reg_line(logic [7:0] a);
    return a[3:2];
  endfunction
endpackage

// *** hdl/kms_link_if.sv ***
`timescale 1ns/10ps
// register strobes between bus slave and core
interface kms_reg_if;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rd_q;
  modport slave(output wr_stb, rd_stb, addr, wdata, rd_q, input rdata);
  modport core(input wr_stb, rd_stb, addr, wdata, rd_q, output rdata);
endinterface // kms_reg_if

// scan timing between sequencer and core
interface kms_tmr_if;
  import kms_pkg::*;
  logic [5:0] osc_div;
  logic [2:0] limit;
  kms_phase_t phase;
  logic [2:0] cath;
  logic [7:0] cath_n;
  logic slot_end;
  logic first_end;
  logic second_end;
  logic seg_on;
  modport timer(input osc_div, limit, output phase, cath, cath_n,
    slot_end, first_end, second_end, seg_on);
  modport core(output osc_div, limit, input phase, cath, cath_n,
    slot_end, first_end, second_end, seg_on);
endinterface // kms_tmr_if

// *** hdl/kms_avmm_slave.sv ***
`timescale 1ns/10ps
`include "kms_defines.svh"
module kms_avmm_slave import kms_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  kms_reg_if.slave rif
);
  kms_slv_st_t r; // ack flag and captured read word
  kms_slv_st_t next_r;

  // one wait state: data captured at the first edge, taken at the second
  always_comb begin
    next_r = r;
    if ((read | write) & ~r.ack) begin
      next_r.ack = 1'b1;
      next_r.rdata = read ? rif.rdata : '0;
    end else begin
      next_r.ack = 1'b0;
    end
  end

  // completion only while enabled, so a frozen block never drops access
  assign waitrequest = ~(r.ack & ce);
  assign readdata = r.rdata;
  assign rif.wr_stb = write & r.ack & ce;
  assign rif.rd_stb = read & r.ack & ce;
  assign rif.addr = address;
  assign rif.wdata = writedata;
  assign rif.rd_q = r.rdata; // lets the core clear only bits returned

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end
endmodule // kms_avmm_slave

// *** hdl/kms_scan_timer.sv ***
`timescale 1ns/10ps
`include "kms_defines.svh"
module kms_scan_timer import kms_pkg::*; #(
  parameter int SLOT_TICKS = `KMS_SLOT_TICKS // oscillator ticks per slot
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  kms_tmr_if.timer tmr
);
  localparam kms_tmr_st_t TMR_RST = '{phase: KMS_PH_FIRST,
    cath_n: `KMS_CATH_N_RST, default: '0};
  kms_tmr_st_t r; // sequencer state
  kms_tmr_st_t next_r;
  logic osc_tick; // one oscillator period elapsed
  logic slot_last; // last clock of a cathode slot
  logic [6:0] nslot; // slot index after this one

  // oscillator prescale, slot timing and window sequence
  always_comb begin
    next_r = r;
    osc_tick = r.osc_cnt >= tmr.osc_div - 6'h01;
    slot_last = osc_tick && r.tick_cnt == 10'(SLOT_TICKS - 1);
    nslot = (r.slot_ix == 7'(`KMS_CYCLE_SLOTS - 1)) ? 7'h00 :
      r.slot_ix + 7'h01;
    next_r.osc_cnt = osc_tick ? 6'h00 : r.osc_cnt + 6'h01;
    if (osc_tick) begin
      next_r.tick_cnt = slot_last ? 10'h000 : r.tick_cnt + 10'h001;
    end
    // segments lit for the first 7/16 of each slot
    next_r.seg_on = next_r.tick_cnt <
      10'(SLOT_TICKS * `KMS_DUTY_NUM / `KMS_DUTY_DEN);
    if (slot_last) begin
      next_r.slot_ix = nslot;
      // one cathode low at a time, wrapping at the scan limit
      next_r.cath = (r.cath >= tmr.limit) ? 3'h0 : r.cath + 3'h1;
      next_r.cath_n = ~(8'h01 << next_r.cath);
      // first test, debounce gap, second test, idle rest
      if (nslot < 7'(`KMS_TEST_SLOTS)) begin
        next_r.phase = KMS_PH_FIRST;
      end else if (nslot < 7'(`KMS_TEST_SLOTS + `KMS_DEB_SLOTS)) begin
        next_r.phase = KMS_PH_WAIT;
      end else if (nslot <
          7'(2 * `KMS_TEST_SLOTS + `KMS_DEB_SLOTS)) begin
        next_r.phase = KMS_PH_SECOND;
      end else begin
        next_r.phase = KMS_PH_REST;
      end
    end
  end

  assign tmr.phase = r.phase;
  assign tmr.cath = r.cath;
  assign tmr.cath_n = r.cath_n;
  assign tmr.seg_on = r.seg_on;
  assign tmr.slot_end = slot_last & ce;
  assign tmr.first_end = slot_last & ce & (r.phase == KMS_PH_FIRST) &
    (nslot == 7'(`KMS_TEST_SLOTS));
  assign tmr.second_end = slot_last & ce & (r.phase == KMS_PH_SECOND) &
    (nslot == 7'(2 * `KMS_TEST_SLOTS + `KMS_DEB_SLOTS));

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= TMR_RST;
    end else if (ce) begin
      r <= next_r;
    end
  end
endmodule // kms_scan_timer

// *** tb/kms_key_scan_props.sv ***
`timescale 1ns/10ps
`include "kms_defines.svh"
// pin and bus checks seen from outside the key scanner
module kms_key_scan_props import kms_pkg::*; #(
  parameter int SLOT_TICKS = `KMS_SLOT_TICKS // oscillator ticks per slot
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic port_pin_four_interrupt_out,
  input wire logic port_pin_four_interrupt_oe,
  input wire logic [7:0] cathode_drive_outputs,
  input wire logic segment_drive_all,
  input wire logic decimal_point_segment,
  input wire logic display_test_active
);
  logic [7:0] cath_q; // cathodes one clock back
  logic [15:0] gap; // clocks since the cathodes last moved
  // reset copies the reset pattern so a mid-run reset is no step
  always_ff @(posedge clk) begin
    cath_q <= srst ? `KMS_CATH_N_RST : cathode_drive_outputs;
    if (srst || cath_q != cathode_drive_outputs) begin
      gap <= 16'h0000;
    end else if (gap != 16'hffff) begin
      gap <= gap + 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_ONE_LOW: assert property ($onehot(~cathode_drive_outputs))
    else $error("cathode outputs not exactly one low");
  AST_CATH_STEP: assert property (cathode_drive_outputs != cath_q |->
    cathode_drive_outputs == {cath_q[6:0], 1'b1} ||
    cathode_drive_outputs == 8'hfe) else $error("cathode out of turn");
  // shortest slot is SLOT_TICKS ticks at the fastest oscillator
  AST_SLOT_LEN: assert property (cathode_drive_outputs != cath_q |->
    gap >= 16'(SLOT_TICKS * `KMS_DIV_MIN - 2))
    else $error("cathode slot too short");
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && ce &&
    avs_waitrequest |=> !avs_waitrequest || !ce)
    else $error("bus answer late");
  AST_ACK_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer longer than one cycle");
  AST_IDLE_BUSY: assert property (!avs_read && !avs_write |->
    avs_waitrequest) else $error("answer without request");
  AST_IRQ_FALL: assert property ($fell(port_pin_four_interrupt_oe) &&
    !port_pin_four_interrupt_out |-> !$past(avs_waitrequest) &&
    ($past(avs_write) || ($past(avs_address) >= `KMS_REG_DEB &&
    $past(avs_address) < 8'h40)))
    else $error("interrupt dropped without debounced read");
  AST_PRESS_QUIET: assert property (avs_read && !avs_waitrequest &&
    avs_address[7:4] == 4'h2 |=> $stable(port_pin_four_interrupt_oe))
    else $error("pressed read moved interrupt");
  AST_SEG_TEST: assert property (segment_drive_all |->
    display_test_active && decimal_point_segment)
    else $error("segments lit outside display test");
endmodule // kms_key_scan_props

bind kms_key_scan kms_key_scan_props #(.SLOT_TICKS(SLOT_TICKS)) u_props (
  .clk(clk), .srst(srst),
  .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .port_pin_four_interrupt_out(port_pin_four_interrupt_out),
  .port_pin_four_interrupt_oe(port_pin_four_interrupt_oe),
  .cathode_drive_outputs(cathode_drive_outputs),
  .segment_drive_all(segment_drive_all),
  .decimal_point_segment(decimal_point_segment),
  .display_test_active(display_test_active));

// *** tb/kms_key_matrix.sv ***
`timescale 1ns/10ps
// diode key matrix; return lines are pulled up when no key conducts
module kms_key_matrix import kms_pkg::*; (
  input wire logic [7:0] cathode_drive_outputs,
  input wire kms_keys_t keys_closed,
  output logic [3:0] port_pins_low_four
);
  // a closed key pulls its line low only while its cathode is low
  always_comb begin
    for (int j = 0; j < 4; j++) begin
      port_pins_low_four[j] = ~|(keys_closed[j] & ~cathode_drive_outputs);
    end
  end
endmodule // kms_key_matrix

// *** tb/kms_key_scan_test.sv ***
`timescale 1ns/10ps
`include "kms_defines.svh"
module kms_key_scan_test import kms_pkg::*;;
  localparam int TB_TICKS = 16; // short slots keep the run brief
  localparam int TB_DIV = 5; // fastest oscillator divide
  logic clk, srst, ce, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address, cath;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] ret; // return lines from the matrix
  logic pin_out, pin_oe, seg, dp, dtest;
  kms_keys_t keys; // closed keys, line by cathode
  int mismatches, num_checks;
  kms_key_scan #(.SLOT_TICKS(TB_TICKS)) uut (.clk(clk), .srst(srst),
    .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port_pins_low_four(ret),
    .port_pin_four_interrupt_out(pin_out),
    .port_pin_four_interrupt_oe(pin_oe), .cathode_drive_outputs(cath),
    .segment_drive_all(seg), .decimal_point_segment(dp),
    .display_test_active(dtest));
  kms_key_matrix u_keys (.cathode_drive_outputs(cath), .keys_closed(keys),
    .port_pins_low_four(ret));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    // only the watchdog ends a wait that never completes
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // let the release land before another request
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask
  // poll the status phase field; scan cycles are long so the bound is wide
  task automatic wait_phase(input logic [3:0] ph);
    int n;
    n = 0;
    do begin
      bus(1'b0, `KMS_REG_STAT, 32'h0000_0000);
      n++;
    end while (q[7:4] !== ph && n < 200000);
    if (n >= 200000) mismatches++;
  endtask
  task automatic conclude;
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // cuts a hang short; three short scan cycles need about 31k clocks
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    conclude;
  end
  initial begin
    int n;
    srst = 1'b1;
    ce = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    keys = '0;
    mismatches = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check(cath, 8'hfe);
    check({pin_oe, pin_out}, 2'h2);
    rd(`KMS_REG_DIV, 32'h0000_000a);
    rd(`KMS_REG_MASK, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    // shortest tick, mask only key A2, scan all lines and digits
    bus(1'b1, `KMS_REG_DIV, 32'h0000_0005);
    bus(1'b1, `KMS_REG_MASK, 32'h0000_0004);
    bus(1'b1, `KMS_REG_CTRL, 32'h0000_01cf);
    keys[0][2] <= 1'b1;
    keys[1][5] <= 1'b1;
    check({pin_oe, pin_out}, 2'h0);
    wait_phase(4'h4);
    rd(8'h20, 32'h0000_0004);
    rd(8'h24, 32'h0000_0020);
    rd(8'h28, 32'h0000_0000);
    check(pin_oe, 1'b0);
    wait_phase(4'h8);
    check(pin_oe, 1'b1);
    rd(8'h24, 32'h0000_0020);
    check(pin_oe, 1'b1);
    rd(8'h34, 32'h0000_0020);
    check(pin_oe, 1'b0);
    rd(8'h34, 32'h0000_0000);
    rd(8'h30, 32'h0000_0004);
    // release A2, keep B5 held, close unmasked C0
    keys[0][2] <= 1'b0;
    keys[2][0] <= 1'b1;
    wait_phase(4'h1);
    wait_phase(4'h2);
    rd(8'h20, 32'h0000_0000);
    rd(8'h28, 32'h0000_0001);
    wait_phase(4'h8);
    check(pin_oe, 1'b0);
    rd(8'h38, 32'h0000_0001);
    rd(8'h34, 32'h0000_0000);
    // display test leaves the other control fields alone
    bus(1'b1, `KMS_REG_CTRL, 32'h0000_01ef);
    check(dtest, 1'b1);
    rd(`KMS_REG_CTRL, 32'h0000_01ef);
    // skip a part-lit slot, then time one whole lit stretch
    n = 0;
    while (seg !== 1'b0 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    while (seg !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    check({seg, dp}, 2'h3);
    n = 0;
    while (seg === 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    check(n, 32'(TB_TICKS * `KMS_DUTY_NUM / `KMS_DUTY_DEN * TB_DIV));
    // a short scan limit leaves higher cathodes unread
    bus(1'b1, `KMS_REG_CTRL, 32'h0000_00cf);
    check(dtest, 1'b0);
    wait_phase(4'h1);
    wait_phase(4'h2);
    rd(8'h24, 32'h0000_0000);
    rd(8'h28, 32'h0000_0001);
    conclude;
  end
endmodule // kms_key_scan_test
